// ---- operand_address_generator.sv ----
/*
 Operand address generator: resolves the addressing mode, fetches the
 operand bytes and pointers over a byte memory port, and answers with
 the effective address or the relative branch target.
 Assumes memory answers a read with mem_valid some cycles later and
 that a new request is only given while busy is low.
*/
// Summary of operation
// - Immediate: byte after opcode is the operand, read from memory at pc_next.
// - Short direct: one address byte, zero page reach.
// - Long direct: two address bytes, full 64K reach.
// - Indexed: unsigned sum of chosen index register and offset.
// - No-offset indexed: no extra byte, index alone is the address.
// - Short indexed: one byte offset plus index, up to 1FE.
// - Long indexed: two byte offset plus index, full 64K.
// - Short indirect: pointer address byte, one byte pointer read.
// - Indirect: pointer address after opcode; long reads a word.
// - Indirect indexed: pointer read from memory plus index.
// - Short indirect indexed up to 1FE; long uses word pointer.
// - Short-only instructions refuse long direct, long indexed and immediate forms.
// - Relative: add signed 8-bit offset to program counter.
// - Relative direct: offset is byte after opcode.
// - Relative indirect: offset read from memory at given address.
// - Decoder serves 63 instructions in 13 groups.
// - Prefix 90 selects the second index register.
// - Prefix 92 turns direct, offset indexed and relative direct forms into indirect ones.
// - Prefix 91 makes indirect indexed use the second index.
`timescale 1ns/1ps
`default_nettype none

module operand_address_generator
	import opaddr_pkg::*;
#(
	parameter int NUM_INSTR = INSTR_COUNT,
	parameter int NUM_GROUPS = GROUP_COUNT
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Request from decode
	input wire logic req_valid,
	input wire addr_req_t req,
	// Memory read port
	output var mem_req_t mem_ff,
	input wire logic mem_valid,
	input wire logic [7:0] mem_data,
	// Answer
	output logic busy_ff,
	output logic done_ff,
	output var addr_ans_t ans_ff
);

	// ==========================================================
	// Size check
	if (NUM_INSTR != INSTR_COUNT || NUM_GROUPS != GROUP_COUNT)
	begin
		$error("Instruction set size not supported");
	end

	// ==========================================================
	// Mode resolution
	addr_mode_t fmode;
	logic sec_idx;
	logic [1:0] olen;
	logic ill;

	mode_resolver u_res (
		.raw_mode(req.mode),
		.prefix(req.prefix),
		.short_only(req.short_only),
		.final_mode(fmode),
		.use_second_index(sec_idx),
		.op_len(olen),
		.illegal(ill)
	);

	// ==========================================================
	// Sequencer
	typedef enum logic [2:0] {
		S_IDLE,
		S_BYTE1,
		S_BYTE2,
		S_PTR1,
		S_PTR2,
		S_FINISH
	} seq_state_t;

	seq_state_t state_ff, nxt_state;
	addr_mode_t mode_ff, nxt_mode;
	logic [7:0] idx_ff, nxt_idx;
	logic [15:0] pc_ff, nxt_pc;
	logic [7:0] b1_ff, nxt_b1;
	logic [7:0] b2_ff, nxt_b2;
	mem_req_t nxt_mem;
	logic nxt_busy;
	logic nxt_done;
	addr_ans_t nxt_ans;
	logic [15:0] pc_after;
	logic [15:0] word_val;
	logic [8:0] short_sum;

	// ==========================================================
	// Sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_idx = idx_ff;
		nxt_pc = pc_ff;
		nxt_b1 = b1_ff;
		nxt_b2 = b2_ff;
		nxt_mem = mem_ff;
		nxt_ans = ans_ff;
		word_val = {b1_ff, b2_ff};
		short_sum = {1'b0, b1_ff} + {1'b0, idx_ff};
		pc_after = pc_ff;
		case (state_ff)
			S_IDLE:
			begin
				if (req_valid)
				begin
					nxt_mode = fmode;
					nxt_idx = sec_idx ? req.y_reg : req.x_reg;
					nxt_pc = req.pc_next;
					nxt_ans = '0;
					nxt_ans.op_len = olen;
					nxt_ans.illegal = ill;
					if (ill || olen == LEN_NONE)
						nxt_state = S_FINISH;
					else
					begin
						nxt_mem.rd = 1'b1;
						nxt_mem.addr = req.pc_next;
						nxt_state = S_BYTE1;
					end
				end
			end
			S_BYTE1:
			begin
				nxt_mem.rd = 1'b0;
				if (mem_valid)
				begin
					nxt_b1 = mem_data;
					nxt_pc = pc_ff + 16'h0001;
					case (mode_ff)
						AM_LONG_DIRECT, AM_IDX_LONG:
						begin
							nxt_mem.rd = 1'b1;
							nxt_mem.addr = pc_ff + 16'h0001;
							nxt_state = S_BYTE2;
						end
						AM_IND_SHORT, AM_IND_LONG, AM_INDIDX_SHORT,
						AM_INDIDX_LONG, AM_REL_INDIRECT:
						begin
							nxt_mem.rd = 1'b1;
							nxt_mem.addr = {8'h00, mem_data};
							nxt_state = S_PTR1;
						end
						default: nxt_state = S_FINISH;
					endcase
				end
			end
			S_BYTE2:
			begin
				nxt_mem.rd = 1'b0;
				if (mem_valid)
				begin
					nxt_b2 = mem_data;
					nxt_pc = pc_ff + 16'h0001;
					nxt_state = S_FINISH;
				end
			end
			S_PTR1:
			begin
				nxt_mem.rd = 1'b0;
				if (mem_valid)
				begin
					if (mode_ff == AM_IND_LONG || mode_ff == AM_INDIDX_LONG)
					begin
						nxt_b2 = mem_data;
						nxt_mem.rd = 1'b1;
						nxt_mem.addr = mem_ff.addr + 16'h0001;
						nxt_state = S_PTR2;
					end
					else
					begin
						nxt_b1 = mem_data;
						nxt_state = S_FINISH;
					end
				end
			end
			S_PTR2:
			begin
				nxt_mem.rd = 1'b0;
				if (mem_valid)
				begin
					nxt_b1 = b2_ff;
					nxt_b2 = mem_data;
					nxt_state = S_FINISH;
				end
			end
			S_FINISH:
			begin
				nxt_state = S_IDLE;
				nxt_ans.has_operand = 1'b0;
				nxt_ans.is_branch = 1'b0;
				if (!ans_ff.illegal)
				begin
					case (mode_ff)
						AM_IMMEDIATE:
						begin
							nxt_ans.operand = b1_ff;
							nxt_ans.has_operand = 1'b1;
						end
						AM_SHORT_DIRECT, AM_IND_SHORT:
							nxt_ans.ea = {8'h00, b1_ff};
						AM_LONG_DIRECT, AM_IND_LONG:
							nxt_ans.ea = word_val;
						AM_IDX_NONE:
							nxt_ans.ea = {8'h00, idx_ff};
						AM_IDX_SHORT, AM_INDIDX_SHORT:
							nxt_ans.ea = {7'h00, short_sum};
						AM_IDX_LONG, AM_INDIDX_LONG:
							nxt_ans.ea = word_val + {8'h00, idx_ff};
						AM_REL_DIRECT, AM_REL_INDIRECT:
						begin
							nxt_ans.is_branch = 1'b1;
							nxt_ans.pc_target = pc_after +
								{{8{b1_ff[7]}}, b1_ff};
						end
						default: nxt_ans.ea = ADDR_RESET;
					endcase
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	// ==========================================================
	// Sequencer registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= S_IDLE;
			mode_ff <= AM_INHERENT;
			idx_ff <= BYTE_RESET;
			pc_ff <= ADDR_RESET;
			b1_ff <= BYTE_RESET;
			b2_ff <= BYTE_RESET;
			mem_ff <= '0;
			ans_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			mode_ff <= nxt_mode;
			idx_ff <= nxt_idx;
			pc_ff <= nxt_pc;
			b1_ff <= nxt_b1;
			b2_ff <= nxt_b2;
			mem_ff <= nxt_mem;
			ans_ff <= nxt_ans;
		end
	end

	// ==========================================================
	// Status flags: busy from take to answer, done for one cycle
	always_comb
	begin
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (state_ff == S_IDLE && req_valid)
			nxt_busy = 1'b1;
		if (state_ff == S_FINISH)
		begin
			nxt_busy = 1'b0;
			nxt_done = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

endmodule

`default_nettype wire

// ---- opaddr_pkg.sv ----
/*
 Package for the operand address generator: addressing modes,
 prefix byte values, operand lengths and the request/answer structs.
 Assumes a 16-bit address space and byte-wide memory.
*/
package opaddr_pkg;

	// ==========================================================
	// Prefix bytes
	localparam logic [7:0] PFX_SECOND_INDEX = 8'h90;
	localparam logic [7:0] PFX_SECOND_INDIRECT = 8'h91;
	localparam logic [7:0] PFX_INDIRECT = 8'h92;

	// ==========================================================
	// Reset values and instruction set sizes
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int INSTR_COUNT = 63;
	localparam int GROUP_COUNT = 13;

	// ==========================================================
	// Addressing modes as given by the fetch stage, before any prefix
	typedef enum logic [3:0] {
		AM_INHERENT,
		AM_IMMEDIATE,
		AM_SHORT_DIRECT,
		AM_LONG_DIRECT,
		AM_IDX_NONE,
		AM_IDX_SHORT,
		AM_IDX_LONG,
		AM_IND_SHORT,
		AM_IND_LONG,
		AM_INDIDX_SHORT,
		AM_INDIDX_LONG,
		AM_REL_DIRECT,
		AM_REL_INDIRECT
	} addr_mode_t;

	// Operand bytes following the opcode, per final mode
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;

	// Request from the decode stage
	typedef struct packed {
		addr_mode_t mode;
		logic [7:0] prefix;
		logic short_only;
		logic [15:0] pc_next;
		logic [7:0] x_reg;
		logic [7:0] y_reg;
	} addr_req_t;

	// Answer to the execute stage
	typedef struct packed {
		logic [15:0] ea;
		logic [7:0] operand;
		logic has_operand;
		logic is_branch;
		logic [15:0] pc_target;
		logic [1:0] op_len;
		logic illegal;
	} addr_ans_t;

	// Memory read port
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} mem_req_t;

endpackage

// ---- mode_resolver.sv ----
/*
 Mode resolver: applies the prefix byte to the raw addressing mode,
 picks the index register and gives the operand byte count.
 Assumes the prefix input is zero when no prefix precedes the opcode.
*/
`timescale 1ns/1ps
`default_nettype none

module mode_resolver
	import opaddr_pkg::*;
(
	// Raw decode
	input wire addr_mode_t raw_mode,
	input wire logic [7:0] prefix,
	input wire logic short_only,
	// Resolved
	output var addr_mode_t final_mode,
	output logic use_second_index,
	output logic [1:0] op_len,
	output logic illegal
);

	always_comb
	begin
		final_mode = raw_mode;
		use_second_index = 1'b0;
		illegal = 1'b0;
		case (prefix)
			PFX_SECOND_INDEX:
			begin
				use_second_index = 1'b1;
				if (raw_mode inside {AM_IND_SHORT, AM_IND_LONG, AM_INDIDX_SHORT,
					AM_INDIDX_LONG, AM_REL_DIRECT, AM_REL_INDIRECT})
					illegal = 1'b1;
			end
			PFX_INDIRECT, PFX_SECOND_INDIRECT:
			begin
				use_second_index = (prefix == PFX_SECOND_INDIRECT);
				case (raw_mode)
					AM_SHORT_DIRECT: final_mode = AM_IND_SHORT;
					AM_LONG_DIRECT: final_mode = AM_IND_LONG;
					AM_IDX_SHORT: final_mode = AM_INDIDX_SHORT;
					AM_IDX_LONG: final_mode = AM_INDIDX_LONG;
					AM_REL_DIRECT: final_mode = AM_REL_INDIRECT;
					default: illegal = 1'b1;
				endcase
				if (prefix == PFX_SECOND_INDIRECT &&
					!(raw_mode inside {AM_IDX_SHORT, AM_IDX_LONG}))
					illegal = 1'b1;
			end
			default: ;
		endcase
		if (short_only && final_mode inside {AM_LONG_DIRECT, AM_IDX_LONG,
			AM_IMMEDIATE})
			illegal = 1'b1;
		case (final_mode)
			AM_INHERENT, AM_IDX_NONE: op_len = LEN_NONE;
			AM_LONG_DIRECT, AM_IDX_LONG: op_len = LEN_TWO;
			default: op_len = LEN_ONE;
		endcase
	end

endmodule

`default_nettype wire

// ---- opaddr_checker_assertions.sv ----
/* Assertions on the operand address generator ports.
 Assumes one clock with an async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module opaddr_checker
	import opaddr_pkg::*;
#(
	parameter int NUM_INSTR = INSTR_COUNT,
	parameter int NUM_GROUPS = GROUP_COUNT
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Request and memory
	input wire logic req_valid,
	input wire addr_req_t req,
	input wire mem_req_t mem_ff,
	input wire logic mem_valid,
	input wire logic [7:0] mem_data,
	// Answer
	input wire logic busy_ff,
	input wire logic done_ff,
	input wire addr_ans_t ans_ff
);
	// ====
	// Properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic take;
	logic plain;
	assign take = req_valid && !busy_ff;
	assign plain = take && req.prefix == 8'h00 && !req.short_only;
	a_first_read: assert property (
		plain && req.mode inside {AM_IMMEDIATE, AM_SHORT_DIRECT, AM_REL_DIRECT}
		|=> mem_ff.rd && mem_ff.addr == $past(req.pc_next))
		else $error("first read");
	a_no_offset: assert property (
		plain && req.mode == AM_IDX_NONE |=> !mem_ff.rd ##1
		done_ff && ans_ff.ea == {8'h00, $past(req.x_reg, 2)})
		else $error("no offset");
	a_short_only: assert property (
		take && req.short_only && req.mode == AM_LONG_DIRECT
		|-> ##2 done_ff && ans_ff.illegal) else $error("short only");
	a_illegal_fast: assert property (
		done_ff && ans_ff.illegal |-> $past(take, 2) && !$past(mem_ff.rd))
		else $error("illegal slow");
	a_branch_len: assert property (
		done_ff && ans_ff.is_branch |-> ans_ff.op_len == LEN_ONE)
		else $error("branch len");
	a_done_pulse: assert property (done_ff |-> !busy_ff ##1 !done_ff)
		else $error("done pulse");
	a_rd_pulse: assert property (mem_ff.rd |-> busy_ff ##1 !mem_ff.rd)
		else $error("rd pulse");
	a_ans_hold: assert property (!busy_ff && !done_ff |-> $stable(ans_ff))
		else $error("ans hold");
	c_illegal: cover property (done_ff && ans_ff.illegal);
	c_branch: cover property (done_ff && ans_ff.is_branch);
	c_top_sum: cover property (done_ff && ans_ff.ea == 16'h01FE);
endmodule
bind operand_address_generator opaddr_checker #(.NUM_INSTR(NUM_INSTR),
	.NUM_GROUPS(NUM_GROUPS)) chk (.ref_clk(ref_clk), .rst(rst),
	.req_valid(req_valid), .req(req), .mem_ff(mem_ff),
	.mem_valid(mem_valid), .mem_data(mem_data), .busy_ff(busy_ff),
	.done_ff(done_ff), .ans_ff(ans_ff));
`default_nettype wire

// ---- opaddr_mem_model.sv ----
/* Byte memory behind the read port, answering 1 to 3 cycles late.
 Assumes one read outstanding at a time. */
`timescale 1ns/1ps
`default_nettype none
module opaddr_mem_model
	import opaddr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Read port
	input wire mem_req_t mem_req,
	input wire logic [1:0] lat,
	output logic mem_valid,
	output logic [7:0] mem_data
);
	// ====
	// Delay line
	logic [1:0] left;
	logic [1:0] cnt_ff;
	logic [15:0] a;
	logic [15:0] a_ff;
	assign left = mem_req.rd ? lat : cnt_ff;
	assign a = mem_req.rd ? mem_req.addr : a_ff;
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			cnt_ff <= 2'h0;
			a_ff <= 16'h0000;
			mem_valid <= 1'b0;
			mem_data <= 8'h00;
		end
		else
		begin
			cnt_ff <= (left == 2'h0) ? 2'h0 : left - 2'h1;
			a_ff <= a;
			mem_valid <= left == 2'h1;
			// Content scrambles the address; idle data toggles
			mem_data <= (left == 2'h1) ? a[7:0] ^ a[15:8] ^ 8'hA5 : ~mem_data;
		end
endmodule
`default_nettype wire

// ---- operand_address_generator_tb.sv ----
/* Testbench of the operand address generator with a memory model.
 Assumes the memory content of opaddr_mem_model. */
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb
	import opaddr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	addr_req_t req = '0;
	logic [1:0] lat = 2'h1;
	mem_req_t mem;
	logic mem_valid;
	logic [7:0] mem_data;
	logic busy;
	logic done;
	addr_ans_t ans;
	int n_errors = 0;
	int tests_run = 0;
	int seed = 71951;
	int cycles = 0;
	// Mode, short-only, prefix
	logic [15:0] tbl [35] = '{16'h0000, 16'h1000, 16'h2000, 16'h3000,
		16'h4000, 16'h5000, 16'h6000, 16'h7000, 16'h8000, 16'h9000,
		16'hA000, 16'hB000, 16'hC000, 16'h1090, 16'h4090, 16'h5090,
		16'h6090, 16'h9091, 16'hA091, 16'h2092, 16'h5092, 16'h6092,
		16'hB092, 16'h7090, 16'hB090, 16'h2091, 16'h1092, 16'h4092,
		16'h1100, 16'h3100, 16'h2100, 16'h3092, 16'h5091, 16'h6091,
		16'h6100};
	always #4 ref_clk = ~ref_clk;
	operand_address_generator dut (.ref_clk(ref_clk), .rst(rst),
		.req_valid(req_valid), .req(req), .mem_ff(mem),
		.mem_valid(mem_valid), .mem_data(mem_data), .busy_ff(busy),
		.done_ff(done), .ans_ff(ans));
	opaddr_mem_model mem_model (.ref_clk(ref_clk), .rst(rst),
		.mem_req(mem), .lat(lat), .mem_valid(mem_valid),
		.mem_data(mem_data));
	function automatic logic [7:0] mb(logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	function automatic logic [15:0] mw(logic [15:0] a);
		return {mb(a), mb(a + 16'h0001)};
	endfunction
	task automatic wrap_up;
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask
	// ====
	// One request against the model
	task automatic run(addr_mode_t m, logic [7:0] p, logic so,
		logic [15:0] pc, logic [7:0] x, logic [7:0] y);
		addr_mode_t f;
		logic [7:0] ix;
		logic [7:0] b;
		logic [7:0] o;
		logic [15:0] e;
		logic [1:0] len;
		logic bad;
		int k;
		b = mb(pc);
		o = b;
		f = m;
		ix = (p == 8'h90 || p == 8'h91) ? y : x;
		bad = 1'b0;
		if (p == 8'h92 || p == 8'h91)
			case (m)
				AM_SHORT_DIRECT: f = AM_IND_SHORT;
				AM_LONG_DIRECT: f = AM_IND_LONG;
				AM_IDX_SHORT: f = AM_INDIDX_SHORT;
				AM_IDX_LONG: f = AM_INDIDX_LONG;
				AM_REL_DIRECT: f = AM_REL_INDIRECT;
				default: bad = 1'b1;
			endcase
		if (p == 8'h91 && !(m inside {AM_IDX_SHORT, AM_IDX_LONG}))
			bad = 1'b1;
		if (p == 8'h90 && m > AM_IDX_LONG)
			bad = 1'b1;
		if (so && f inside {AM_IMMEDIATE, AM_LONG_DIRECT, AM_IDX_LONG})
			bad = 1'b1;
		case (f)
			AM_LONG_DIRECT: e = mw(pc);
			AM_IDX_NONE: e = {8'h00, ix};
			AM_IDX_SHORT: e = b + ix;
			AM_IDX_LONG: e = mw(pc) + ix;
			AM_IND_SHORT: e = mb({8'h00, b});
			AM_IND_LONG: e = mw({8'h00, b});
			AM_INDIDX_SHORT: e = mb({8'h00, b}) + ix;
			AM_INDIDX_LONG: e = mw({8'h00, b}) + ix;
			default: e = {8'h00, b};
		endcase
		if (f == AM_REL_INDIRECT)
			o = mb({8'h00, b});
		if (f >= AM_REL_DIRECT)
			e = pc + 16'h0001 + {{8{o[7]}}, o};
		len = (f inside {AM_INHERENT, AM_IDX_NONE}) ? LEN_NONE :
			(f inside {AM_LONG_DIRECT, AM_IDX_LONG}) ? LEN_TWO : LEN_ONE;
		req_valid <= 1'b1;
		req <= addr_req_t'{m, p, so, pc, x, y};
		@(posedge ref_clk);
		req.mode <= AM_INHERENT;
		req.x_reg <= ~x;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (k = 0; k < 100 && done !== 1'b1; k++)
			@(posedge ref_clk);
		chk("done", 16'h0001, 16'(done));
		chk("illegal", 16'(bad), 16'(ans.illegal));
		if (!bad)
		begin
			chk("len", 16'(len), 16'(ans.op_len));
			chk("branch", 16'(f >= AM_REL_DIRECT), 16'(ans.is_branch));
			if (f == AM_IMMEDIATE)
				chk("operand", {8'h01, b}, {7'h00, ans.has_operand, ans.operand});
			else if (f >= AM_REL_DIRECT)
				chk("target", e, ans.pc_target);
			else if (f != AM_INHERENT)
				chk("ea", e, ans.ea);
		end
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			wrap_up;
		end
	end
	initial
	begin
		logic [15:0] pc;
		logic [15:0] t;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 35; i++)
			repeat (2)
			begin
				pc = 16'($random(seed));
				if (mb(pc) == 8'hFF)
					pc[0] = ~pc[0];
				t = tbl[i];
				lat <= 2'h1 + 2'($unsigned($random(seed)) % 3);
				run(addr_mode_t'(t[15:12]), t[7:0], t[8], pc,
					8'($random(seed)), 8'($random(seed)));
			end
		run(AM_IDX_SHORT, 8'h00, 1'b0, 16'h005A, 8'hFF, 8'h00);
		run(AM_IDX_SHORT, 8'h92, 1'b0, 16'h00FF, 8'hFF, 8'h00);
		wrap_up;
	end
endmodule
`default_nettype wire
